// File: bench/fspc_flash_model.sv
// Behavioural flash array on the far side of the sequencer
`timescale 1ns/1ps
module fspc_flash_model import fspc_pkg::*; #(
    parameter int          PAGE_WORDS = 128,
    parameter logic [31:0] ERASED_W   = 32'hFFFF_FFFF
) (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire fspc_op_e    op,
    input  wire logic [14:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic [7:0]  lat,
    output logic [31:0]      rdata,
    output logic             done
);
    logic [31:0] mem [logic [14:0]];
    logic [7:0]  cnt = 8'h00;
    logic        fin = 1'b0;
    initial rdata = 32'h0000_0000;
    initial done = 1'b0;
    always @(posedge clk) begin
        done <= 1'b0;
        // Read data is only valid with done; garble it otherwise
        rdata <= ~rdata;
        if (!req) begin
            cnt <= 8'h00;
            fin <= 1'b0;
        end else if (!fin && cnt == lat) begin
            fin <= 1'b1;
            done <= 1'b1;
            case (op)
                FSPC_OP_READ: rdata <= mem.exists(addr) ? mem[addr] : ERASED_W;
                FSPC_OP_PROG: mem[addr] = wdata;
                FSPC_OP_ERASE: begin
                    for (int j = 0; j < PAGE_WORDS; j++) begin
                        mem.delete((addr & ~15'(PAGE_WORDS - 1)) + 15'(j));
                    end
                end
                default: ;
            endcase
        end else if (!fin) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// File: bench/fspc_tb_top.sv
// Self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
`define FSPC_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module fspc_tb_top;
    import fspc_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m;} fspc_rd_s;
    typedef struct {fspc_op_e op; logic [14:0] a; logic [31:0] d;
                    logic [31:0] m;} fspc_fl_s;
    localparam logic [31:0] ERASED_W = 32'hFFFF_FFFF;
    logic CLK = 0, RESETN = 0, CYC_I = 0, STB_I = 0, WE_I = 0;
    logic        WPROT_OPEN = 0, ACK_O, FL_REQ, FL_DONE, fl_req_q = 0;
    logic [7:0]  ADR_I = 0, lat = 0;
    logic [3:0]  SEL_I = 0;
    logic [31:0] DAT_I = 0, DAT_O, FL_WDATA, FL_RDATA, rdat, d, dv, seed;
    logic [14:0] FL_ADDR, idx;
    fspc_op_e    FL_OP;
    int          num_errors = 0, tests_run = 0, cyc_cnt = 0;
    fspc_rd_s    rq[$];
    fspc_fl_s    fq[$];

    always #25 CLK = ~CLK;

    fspc_top u_dut (.CLK(CLK), .RESETN(RESETN), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
        .ACK_O(ACK_O), .WPROT_OPEN(WPROT_OPEN), .FL_REQ(FL_REQ), .FL_OP(FL_OP),
        .FL_ADDR(FL_ADDR), .FL_WDATA(FL_WDATA), .FL_RDATA(FL_RDATA),
        .FL_DONE(FL_DONE));
    fspc_flash_model #(.ERASED_W(ERASED_W)) u_flash (.clk(CLK), .req(FL_REQ),
        .op(FL_OP), .addr(FL_ADDR), .wdata(FL_WDATA), .lat(lat),
        .rdata(FL_RDATA), .done(FL_DONE));

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] dat, input logic [3:0] s);
        @(posedge CLK);
        CYC_I <= 1'b1; STB_I <= 1'b1; WE_I <= w;
        ADR_I <= a; DAT_I <= dat; SEL_I <= s;
        do @(posedge CLK); while (ACK_O !== 1'b1);
        rdat = DAT_O;
        CYC_I <= 1'b0; STB_I <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        wb(1'b1, a, dat, 4'hF);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, m);
        rq.push_back('{v, m});
        wb(1'b0, a, 32'h0000_0000, 4'hF);
    endtask
    task automatic go(input logic [31:0] cmd, input logic busy_chk);
        int k;
        k = 0;
        wr(FSPC_OFS_CMD, cmd);
        wr(FSPC_OFS_TRIG, 32'h0000_0001);
        rd(FSPC_OFS_TRIG, 32'h0000_0001, {31'h7FFF_FFFF, busy_chk});
        do begin
            rd(FSPC_OFS_TRIG, 32'h0, 32'hFFFF_FFFE);
            k++;
        end while (rdat[0] !== 1'b0 && k < 100);
        `FSPC_CHK("trigger clear", 1'b0, rdat[0])
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watch outputs and take the oldest note for each result
    always @(posedge CLK) begin
        fl_req_q <= FL_REQ;
        if (ACK_O === 1'b1 && WE_I === 1'b0 && rq.size() > 0) begin
            `FSPC_CHK("read data", rq[0].v & rq[0].m, DAT_O & rq[0].m)
            void'(rq.pop_front());
        end
        if (FL_REQ === 1'b1 && fl_req_q === 1'b0) begin
            if (fq.size() == 0) begin
                `FSPC_CHK("flash request", 1'b0, 1'b1)
            end else begin
                `FSPC_CHK("flash op", fq[0].op, FL_OP)
                `FSPC_CHK("flash addr", fq[0].a, FL_ADDR)
                `FSPC_CHK("flash word", fq[0].d, FL_WDATA & fq[0].m)
                void'(fq.pop_front());
            end
        end
    end
    always @(posedge CLK) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        seed = $urandom(32'h02b188ee);
        repeat (10) @(posedge CLK);
        RESETN <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 32'h0, 32'hFFFF_FFFF);
        end
        wr(FSPC_OFS_CTRL, 32'h0000_0001);
        rd(FSPC_OFS_CTRL, 32'h0, 32'hFFFF_FFFF);
        go(32'(FSPC_CMD_PROG), 1'b0);
        WPROT_OPEN <= 1'b1;
        wr(FSPC_OFS_CTRL, 32'h0000_0001);
        rd(FSPC_OFS_CTRL, 32'h1, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            idx = 15'($urandom_range(32767));
            d = $urandom;
            dv = d ^ 32'h0000_00FF;
            lat <= 8'(i * 8);
            wr(FSPC_OFS_ADDR, {15'h0, idx, 2'b00});
            wr(FSPC_OFS_DATA, d);
            // Only lane 0 changes; the program still stores the whole word
            wb(1'b1, FSPC_OFS_DATA, dv, 4'b0001);
            fq.push_back('{FSPC_OP_PROG, idx, dv, 32'hFFFF_FFFF});
            go(32'(FSPC_CMD_PROG), i > 0);
            wr(FSPC_OFS_DATA, $urandom);
            fq.push_back('{FSPC_OP_READ, idx, 32'h0, 32'h0});
            go(32'(FSPC_CMD_READ), i > 0);
            rd(FSPC_OFS_DATA, dv, 32'hFFFF_FFFF);
        end
        fq.push_back('{FSPC_OP_ERASE, idx, 32'h0, 32'h0});
        go(32'(FSPC_CMD_ERASE), 1'b1);
        fq.push_back('{FSPC_OP_READ, idx, 32'h0, 32'h0});
        go(32'(FSPC_CMD_READ), 1'b1);
        rd(FSPC_OFS_DATA, ERASED_W, 32'hFFFF_FFFF);
        go(32'h0000_0011, 1'b0);
        go(32'h0000_0003, 1'b0);
        wr(FSPC_OFS_ADDR, 32'h0002_0000);
        go(32'(FSPC_CMD_PROG), 1'b0);
        // A read beyond 32K words is skipped and keeps the data register
        wr(FSPC_OFS_DATA, d);
        go(32'(FSPC_CMD_READ), 1'b0);
        rd(FSPC_OFS_DATA, d, 32'hFFFF_FFFF);
        wr(FSPC_OFS_CTRL, 32'h0);
        wr(FSPC_OFS_TRIG, 32'h0000_0001);
        rd(FSPC_OFS_TRIG, 32'h0, 32'hFFFF_FFFF);
        repeat (10) @(posedge CLK);
        `FSPC_CHK("pending flash ops", 0, fq.size())
        `FSPC_CHK("pending reads", 0, rq.size())
        wrap_up();
    end
endmodule

// File: pkg/fspc_pkg.sv
// Constants and types shared by the flash self-programming controller
package fspc_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0]  FSPC_OFS_CTRL  = 8'h00;
    localparam logic [7:0]  FSPC_OFS_ADDR  = 8'h04;
    localparam logic [7:0]  FSPC_OFS_DATA  = 8'h08;
    localparam logic [7:0]  FSPC_OFS_CMD   = 8'h0C;
    localparam logic [7:0]  FSPC_OFS_TRIG  = 8'h10;
    // Field positions
    localparam int          FSPC_EN_BIT    = 0;
    localparam int          FSPC_TRIG_BIT  = 0;
    localparam int          FSPC_WADDR_LSB = 2;
    localparam int          FSPC_CMD_W     = 6;
    localparam int          FSPC_OSEL_BIT  = 5;
    localparam int          FSPC_CBIT_BIT  = 4;
    localparam int          FSPC_FUNC_LSB  = 0;
    localparam int          FSPC_FUNC_W    = 4;
    // Flash array: 32K words of 32 bits
    localparam int          FSPC_FL_AW     = 15;
    localparam int          FSPC_DW        = 32;
    // Reset values
    localparam logic [31:0] FSPC_RST_WORD  = 32'h0000_0000;
    localparam logic [5:0]  FSPC_RST_CMD   = 6'h00;
    localparam logic        FSPC_RST_BIT   = 1'b0;
    // Command encodings {operation select, control bit, function code}
    localparam logic [5:0]  FSPC_CMD_READ  = 6'h00;
    localparam logic [5:0]  FSPC_CMD_PROG  = 6'h21;
    localparam logic [5:0]  FSPC_CMD_ERASE = 6'h22;

    typedef enum logic [1:0] {
        FSPC_OP_READ  = 2'b00,
        FSPC_OP_PROG  = 2'b01,
        FSPC_OP_ERASE = 2'b10,
        FSPC_OP_NONE  = 2'b11
    } fspc_op_e;

    typedef enum logic [1:0] {
        FSPC_S_IDLE = 2'b00,
        FSPC_S_BUSY = 2'b01
    } fspc_state_e;
endpackage

// File: pkg/fspc_seq_if.sv
// Handshake between the register block and the flash sequencer
`timescale 1ns/1ps
interface fspc_seq_if #(parameter int AW = 15);
    import fspc_pkg::*;
    logic              start;
    fspc_op_e          op;
    logic [AW-1:0]     waddr;
    logic [31:0]       wdata;
    logic              done;
    logic [31:0]       rdata;
    modport ctl (output start, op, waddr, wdata, input done, rdata);
    modport seq (input start, op, waddr, wdata, output done, rdata);
endinterface

// File: rtl/fspc_flash_seq.sv
// Flash sequencer: drives one flash operation and reports completion
`timescale 1ns/1ps
module fspc_flash_seq import fspc_pkg::*; #(
    parameter int AW = FSPC_FL_AW
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    fspc_seq_if.seq            sif,
    output logic               fl_req,
    output fspc_op_e           fl_op,
    output logic [AW-1:0]      fl_addr,
    output logic [31:0]        fl_wdata,
    input  wire logic [31:0]   fl_rdata,
    input  wire logic          fl_done
);
    typedef struct packed {
        fspc_state_e   state;
        logic          req;
        fspc_op_e      op;
        logic [AW-1:0] addr;
        logic [31:0]   wdata;
        logic          done;
        logic [31:0]   rdata;
    } fspc_seq_s;

    fspc_seq_s r_reg;
    fspc_seq_s r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        case (r_reg.state)
            FSPC_S_IDLE: begin
                if (sif.start) begin
                    // [RULE10] Flash untouched
                    if (sif.op == FSPC_OP_NONE) begin
                        r_next.done = 1'b1;
                    end else begin
                        r_next.req   = 1'b1;
                        r_next.op    = sif.op;
                        r_next.addr  = sif.waddr;
                        // [RULE3] Whole word write
                        r_next.wdata = sif.wdata;
                        r_next.state = FSPC_S_BUSY;
                    end
                end
            end
            FSPC_S_BUSY: begin
                if (fl_done) begin
                    r_next.req   = 1'b0;
                    r_next.done  = 1'b1;
                    r_next.state = FSPC_S_IDLE;
                    // [RULE6] Capture read word
                    if (r_reg.op == FSPC_OP_READ) begin
                        r_next.rdata = fl_rdata;
                    end
                end
            end
            default: begin
                r_next.state = FSPC_S_IDLE;
                r_next.req   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign fl_req    = r_reg.req;
    assign fl_op     = r_reg.op;
    assign fl_addr   = r_reg.addr;
    assign fl_wdata  = r_reg.wdata;
    assign sif.done  = r_reg.done;
    assign sif.rdata = r_reg.rdata;

    // [RULE3] Request stable
    a_req_stable: assert property ( // [RULE3]
        @(posedge clk) disable iff (!resetn)
        fl_req && !fl_done |=> fl_req && $stable(fl_addr)
            && $stable(fl_wdata) && $stable(fl_op))
        else $error("Flash request changed before completion");
endmodule

// File: rtl/fspc_top.sv
// Flash self-programming controller with a classic Wishbone slave
// How it works
// [RULE1] Enable bit set allows self-programming; cleared disables it.
// [RULE2] Flash array addressed holds at most 32K words of 32 bits.
// [RULE3] Flash is written only as whole 32-bit words.
// [RULE4] Software keeps address bits 1:0 zero when starting an operation.
// [RULE5] Software loads data register first; device programs that word.
// [RULE6] Completed read places the fetched word in the data register.
// [RULE7] Command bit 5 select, bit 4 control, bits 3:0 function.
// [RULE8] Writing trigger bit 0 starts; it reads 1 until hardware clears.
// [RULE9] Enable bit accepts writes only while write protection is open.
// [RULE10] Trigger ignored and flash untouched while enable is cleared.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module fspc_top import fspc_pkg::*; #(
    parameter int FL_AW = FSPC_FL_AW
) (
    input  wire logic              CLK,
    input  wire logic              RESETN,
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    input  wire logic              WE_I,
    input  wire logic [7:0]        ADR_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic [31:0]       DAT_I,
    output logic [31:0]            DAT_O,
    output logic                   ACK_O,
    input  wire logic              WPROT_OPEN,
    output logic                   FL_REQ,
    output fspc_op_e               FL_OP,
    output logic [FL_AW-1:0]       FL_ADDR,
    output logic [31:0]            FL_WDATA,
    input  wire logic [31:0]       FL_RDATA,
    input  wire logic              FL_DONE
);
    typedef struct packed {
        logic                  enable;
        logic [31:0]           addr;
        logic [31:0]           data;
        logic [FSPC_CMD_W-1:0] cmd;
        logic                  busy;
        logic                  start;
        logic                  ack;
        logic [31:0]           rdat;
    } fspc_regs_s;

    fspc_regs_s  r_reg;
    fspc_regs_s  r_next;
    fspc_op_e    op_sel;
    logic        req;
    logic        wr;
    logic        in_range;

    fspc_seq_if #(.AW(FL_AW)) sif ();

    function automatic logic [31:0] fspc_merge(
        input logic [31:0] old,
        input logic [31:0] din,
        input logic [3:0]  sel
    );
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[8*i +: 8] = din[8*i +: 8];
            end
        end
        return m;
    endfunction

    assign req = CYC_I && STB_I && !r_reg.ack;
    assign wr  = req && WE_I;

    // [RULE2] Word index within 32K
    assign in_range = (r_reg.addr[31:FL_AW+FSPC_WADDR_LSB] == '0);

    // [RULE7] Command decode
    always_comb begin
        case (r_reg.cmd)
            FSPC_CMD_READ:  op_sel = FSPC_OP_READ;
            FSPC_CMD_PROG:  op_sel = FSPC_OP_PROG;
            FSPC_CMD_ERASE: op_sel = FSPC_OP_ERASE;
            default:        op_sel = FSPC_OP_NONE;
        endcase
        if (!in_range) begin
            op_sel = FSPC_OP_NONE;
        end
    end

    always_comb begin
        r_next       = r_reg;
        r_next.ack   = 1'b0;
        r_next.start = 1'b0;
        if (req) begin
            r_next.ack  = 1'b1;
            r_next.rdat = FSPC_RST_WORD;
            case (ADR_I[7:2])
                FSPC_OFS_CTRL[7:2]: r_next.rdat[FSPC_EN_BIT] = r_reg.enable;
                FSPC_OFS_ADDR[7:2]: r_next.rdat = r_reg.addr;
                FSPC_OFS_DATA[7:2]: r_next.rdat = r_reg.data;
                FSPC_OFS_CMD[7:2]:  r_next.rdat[FSPC_CMD_W-1:0] = r_reg.cmd;
                FSPC_OFS_TRIG[7:2]: r_next.rdat[FSPC_TRIG_BIT] = r_reg.busy;
                default:            r_next.rdat = FSPC_RST_WORD;
            endcase
        end
        // Operand registers are frozen while an operation runs
        if (wr) begin
            case (ADR_I[7:2])
                FSPC_OFS_CTRL[7:2]: begin
                    // [RULE9] Protected enable write
                    if (WPROT_OPEN && SEL_I[0]) begin
                        r_next.enable = DAT_I[FSPC_EN_BIT];
                    end
                end
                FSPC_OFS_ADDR[7:2]: begin
                    if (!r_reg.busy) begin
                        r_next.addr = fspc_merge(r_reg.addr, DAT_I, SEL_I);
                    end
                end
                FSPC_OFS_DATA[7:2]: begin
                    // [RULE5] Software loads word
                    if (!r_reg.busy) begin
                        r_next.data = fspc_merge(r_reg.data, DAT_I, SEL_I);
                    end
                end
                FSPC_OFS_CMD[7:2]: begin
                    if (!r_reg.busy && SEL_I[0]) begin
                        r_next.cmd = DAT_I[FSPC_CMD_W-1:0];
                    end
                end
                FSPC_OFS_TRIG[7:2]: begin
                    // [RULE1] Enable gates start
                    // [RULE10] Ignore when disabled
                    if (SEL_I[0] && DAT_I[FSPC_TRIG_BIT] && r_reg.enable
                        && !r_reg.busy) begin
                        r_next.busy  = 1'b1;
                        r_next.start = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // [RULE8] Hardware clears trigger
        if (sif.done) begin
            r_next.busy = 1'b0;
            // [RULE6] Read result lands
            // A skipped read must not copy the sequencer's stale word
            if (r_reg.cmd == FSPC_CMD_READ && in_range) begin
                r_next.data = sif.rdata;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            r_reg        <= '0;
            r_reg.addr   <= FSPC_RST_WORD;
            r_reg.data   <= FSPC_RST_WORD;
            r_reg.cmd    <= FSPC_RST_CMD;
            r_reg.enable <= FSPC_RST_BIT;
            r_reg.busy   <= FSPC_RST_BIT;
        end else begin
            r_reg <= r_next;
        end
    end

    // [RULE4] Low address bits dropped
    assign sif.start = r_reg.start;
    assign sif.op    = op_sel;
    assign sif.waddr = r_reg.addr[FL_AW+FSPC_WADDR_LSB-1:FSPC_WADDR_LSB];
    assign sif.wdata = r_reg.data;

    assign DAT_O = r_reg.rdat;
    assign ACK_O = r_reg.ack;

    fspc_flash_seq #(.AW(FL_AW)) u_seq (
        .clk      (CLK),
        .resetn   (RESETN),
        .sif      (sif),
        .fl_req   (FL_REQ),
        .fl_op    (FL_OP),
        .fl_addr  (FL_ADDR),
        .fl_wdata (FL_WDATA),
        .fl_rdata (FL_RDATA),
        .fl_done  (FL_DONE)
    );

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_trig_write;
        wr && ADR_I[7:2] == FSPC_OFS_TRIG[7:2] && SEL_I[0]
            && DAT_I[FSPC_TRIG_BIT];
    endsequence

    sequence s_ctrl_write;
        wr && ADR_I[7:2] == FSPC_OFS_CTRL[7:2] && SEL_I[0];
    endsequence

    // [RULE1] Start needs enable
    a_start_enabled: assert property ( // [RULE1]
        $rose(r_reg.busy) |-> $past(r_reg.enable))
        else $error("Operation started while disabled");

    // [RULE10] Disabled trigger ignored
    a_trig_ignored: assert property ( // [RULE10]
        s_trig_write and !r_reg.enable and !r_reg.busy
            |=> !r_reg.busy ##1 !FL_REQ)
        else $error("Trigger acted while disabled");

    // [RULE9] Enable write protected
    a_enable_protect: assert property ( // [RULE9]
        s_ctrl_write and !WPROT_OPEN |=> $stable(r_reg.enable))
        else $error("Enable changed while protected");

    // [RULE8] Trigger starts operation
    a_trig_starts: assert property ( // [RULE8]
        s_trig_write and r_reg.enable and !r_reg.busy
            |=> r_reg.busy ##1 (FL_REQ || sif.done))
        else $error("Trigger did not start an operation");

    // [RULE8] Busy until completion
    a_busy_holds: assert property ( // [RULE8]
        r_reg.busy && !sif.done |=> r_reg.busy)
        else $error("Trigger bit cleared before completion");

    // [RULE8] Completion clears trigger
    a_done_clears: assert property ( // [RULE8]
        sif.done |=> !r_reg.busy)
        else $error("Trigger bit not cleared on completion");

    // [RULE6] Read word captured
    a_read_capture: assert property ( // [RULE6]
        sif.done && r_reg.cmd == FSPC_CMD_READ && in_range
            |=> r_reg.data == $past(sif.rdata))
        else $error("Read word not placed in data register");

    // [RULE7] Program command decode
    a_cmd_decode: assert property ( // [RULE7]
        sif.start && r_reg.cmd == FSPC_CMD_PROG && in_range
            |=> FL_REQ && FL_OP == FSPC_OP_PROG)
        else $error("Program command not decoded");

    // [RULE3] Programmed word is the data register
    a_word_only: assert property ( // [RULE3]
        FL_REQ && FL_OP == FSPC_OP_PROG |-> FL_WDATA == r_reg.data)
        else $error("Programmed word differs from data register");

    // [RULE2] Word address from register
    a_word_range: assert property ( // [RULE2]
        $rose(FL_REQ) |-> FL_ADDR == $past(sif.waddr) && $past(in_range))
        else $error("Flash address out of 32K word range");
endmodule
